/* core/nco_core.sv */
// Numerically controlled oscillator with serial word load and AHB-Lite registers
`default_nettype none
// Summary of operation
// - Shift serial bit on serial clock rise
// - Shift enable high holds frequency register
// - Direction pin picks LSB or MSB first
// - Select high takes low word, low high
// - Transfer copies selected word after four clocks
// - Accumulator steps only while enable low
// - Load zeroes feedback after five clocks
// - Offset picks quarter turn, four clock delay
// - Offset added to top accumulator bits
// - Thirty-two bit accumulator adds selected increment
// - Sine table maps thirteen bit phase
// - Twelve bit offset binary samples
// - Output bit zero is sample LSB
// - Codes 00,01,10,11 give 0,90,270,180
// - Each clock with enable low, run set, load high and buffer not full adds increment register to accumulator
// - Samples span 001 to FFF around 800
module nco_core #(
  parameter int unsigned FIFO_DEPTH = nco_pkg::FIFO_DEPTH
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  input  wire logic        sclk,
  input  wire logic        serial_word_in,
  input  wire logic        shift_enable_n,
  input  wire logic        shift_msb_first,
  input  wire logic        word_select,
  input  wire logic        word_transfer_n,
  input  wire logic        accumulate_enable_n,
  input  wire logic        accumulator_load_n,
  input  wire logic [1:0]  phase_offset_code,
  output logic [11:0]      sine_sample_out,
  output logic             sample_valid,
  input  wire logic        sample_ready
);
  typedef struct packed {
    logic [nco_pkg::PIN_W-1:0]        pin_s1;
    logic [nco_pkg::PIN_W-1:0]        pin_s2;
    logic                             sclk_prev;
    logic [nco_pkg::FREQ_W-1:0]       freq;
    logic [nco_pkg::WORD_W-1:0]       incr;
    logic [nco_pkg::WORD_W-1:0]       acc;
    logic [nco_pkg::XFER_DELAY-1:0]   xfer_pipe;
    logic [nco_pkg::ACC_DELAY-1:0]    accen_pipe;
    logic [nco_pkg::LOAD_DELAY-1:0]   load_pipe;
    logic [nco_pkg::OFS_DELAY-1:0][1:0] ofs_pipe;
    logic                             run;
    logic                             dp_write;
    logic [7:0]                       dp_addr;
    logic [31:0]                      rdata;
    logic                             readyout;
    logic [nco_pkg::SAMPLE_W-1:0]     out_data;
    logic                             out_valid;
  } nco_state_s;

  nco_state_s                   st_reg;
  nco_state_s                   st_next;
  logic [nco_pkg::PIN_W-1:0]    pins;
  logic [nco_pkg::PIN_W-1:0]    s2;
  logic                         adv;
  logic                         addr_phase;
  logic [nco_pkg::PHASE_W-1:0]  phase;
  logic [nco_pkg::SAMPLE_W-1:0] sine_val;
  logic                         fifo_in_ready;
  logic [nco_pkg::SAMPLE_W-1:0] fifo_out_data;
  logic                         fifo_out_valid;
  logic                         fifo_pop;
  logic [nco_pkg::WORD_W-1:0]   fb;

  // Offset code to quarter turns
  function automatic logic [1:0] nco_qtr(input logic [1:0] code);
    logic [1:0] q;
    q = nco_pkg::QTR_0;
    if (code == 2'h1) begin
      q = nco_pkg::QTR_90;
    end else if (code == 2'h2) begin
      q = nco_pkg::QTR_270;
    end else if (code == 2'h3) begin
      q = nco_pkg::QTR_180;
    end
    return q;
  endfunction

  // Sine of a thirteen bit phase, offset binary
  function automatic logic [11:0] nco_sine(input logic [12:0] ph);
    logic [12:0] p;
    logic [12:0] q;
    logic [25:0] u;
    logic [35:0] num;
    logic [35:0] den;
    logic [11:0] mag;
    p = {1'b0, ph[11:0]};
    q = nco_pkg::HALF_TURN - p;
    u = 26'(p) * 26'(q);
    num = 36'(u) * nco_pkg::SINE_NUM_K;
    den = nco_pkg::SINE_DEN_K - 36'(u);
    mag = 12'(num / den);
    if (ph[12]) begin
      return nco_pkg::SAMPLE_MID - mag;
    end else begin
      return nco_pkg::SAMPLE_MID + mag;
    end
  endfunction

  // Register read mux
  function automatic logic [31:0] nco_read(input nco_state_s s, input logic [7:0] a,
                                           input logic rdy);
    logic [31:0] d;
    d = 32'h00000000;
    if (a == nco_pkg::REG_CTRL) begin
      d[nco_pkg::CTRL_RUN_BIT] = s.run;
    end else if (a == nco_pkg::REG_STATUS) begin
      d[nco_pkg::STAT_VLD_BIT] = s.out_valid;
      d[nco_pkg::STAT_RDY_BIT] = rdy;
      d[nco_pkg::STAT_SEL_BIT] = s.pin_s2[nco_pkg::PIN_SEL];
    end else if (a == nco_pkg::REG_PHASE) begin
      d = s.acc;
    end else if (a == nco_pkg::REG_INCR) begin
      d = s.incr;
    end else if (a == nco_pkg::REG_FREQ_HI) begin
      d = s.freq[63:32];
    end else if (a == nco_pkg::REG_FREQ_LO) begin
      d = s.freq[31:0];
    end
    return d;
  endfunction

  assign pins = {phase_offset_code, accumulator_load_n, accumulate_enable_n, word_transfer_n,
                 word_select, shift_msb_first, shift_enable_n, serial_word_in, sclk};
  assign s2 = st_reg.pin_s2;

  // Phase offset adder and sine table
  assign phase = st_reg.acc[31:19] + {nco_qtr(st_reg.ofs_pipe[nco_pkg::OFS_DELAY-1]), 11'h000};
  assign sine_val = nco_sine(phase);

  assign adv = st_reg.run && fifo_in_ready;
  assign fifo_pop = !st_reg.out_valid || sample_ready;
  assign addr_phase = hsel && hready && (htrans == nco_pkg::HTRANS_NONSEQ || htrans == 2'h3);
  assign fb = st_reg.load_pipe[nco_pkg::LOAD_DELAY-1] ? 32'h00000000 : st_reg.acc;

  nco_fifo #(
    .WIDTH (nco_pkg::SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .in_data   (sine_val),
    .in_valid  (adv),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop)
  );

  always_comb begin
    st_next = st_reg;
    // Pin synchronisers
    st_next.pin_s1 = pins;
    st_next.pin_s2 = st_reg.pin_s1;
    st_next.sclk_prev = s2[nco_pkg::PIN_SCLK];
    // Serial frequency register
    if (s2[nco_pkg::PIN_SCLK] && !st_reg.sclk_prev && !s2[nco_pkg::PIN_SHIFT_ENABLE_N]) begin
      if (s2[nco_pkg::PIN_MSB]) begin
        st_next.freq = {st_reg.freq[62:0], s2[nco_pkg::PIN_SD]};
      end else begin
        st_next.freq = {s2[nco_pkg::PIN_SD], st_reg.freq[63:1]};
      end
    end
    // Control pipelines and accumulator, stalled while the buffer is full
    if (adv) begin
      st_next.xfer_pipe = {st_reg.xfer_pipe[nco_pkg::XFER_DELAY-2:0], !s2[nco_pkg::PIN_XFER]};
      st_next.accen_pipe = {st_reg.accen_pipe[nco_pkg::ACC_DELAY-2:0],
                            !s2[nco_pkg::PIN_ACCEN]};
      st_next.load_pipe = {st_reg.load_pipe[nco_pkg::LOAD_DELAY-2:0], !s2[nco_pkg::PIN_LOAD]};
      st_next.ofs_pipe = {st_reg.ofs_pipe[nco_pkg::OFS_DELAY-2:0],
                          s2[nco_pkg::PIN_OFS+1:nco_pkg::PIN_OFS]};
      if (st_reg.xfer_pipe[nco_pkg::XFER_DELAY-1]) begin
        if (s2[nco_pkg::PIN_SEL]) begin
          st_next.incr = st_reg.freq[31:0];
        end else begin
          st_next.incr = st_reg.freq[63:32];
        end
      end
      if (st_reg.accen_pipe[nco_pkg::ACC_DELAY-1]) begin
        st_next.acc = fb + st_reg.incr;
      end
    end
    // Output register fed from the buffer
    if (fifo_pop) begin
      st_next.out_valid = fifo_out_valid;
      if (fifo_out_valid) begin
        st_next.out_data = fifo_out_data;
      end
    end
    // AHB-Lite slave, zero wait states, always OKAY
    st_next.readyout = 1'b1;
    if (st_reg.dp_write && st_reg.dp_addr == nco_pkg::REG_CTRL) begin
      st_next.run = hwdata[nco_pkg::CTRL_RUN_BIT];
    end
    st_next.dp_write = 1'b0;
    if (addr_phase) begin
      st_next.dp_write = hwrite;
      st_next.dp_addr = {haddr[7:2], 2'b00};
      if (!hwrite) begin
        st_next.rdata = nco_read(st_reg, {haddr[7:2], 2'b00}, fifo_in_ready);
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.run <= nco_pkg::CTRL_RUN_RST;
      st_reg.readyout <= 1'b1;
      st_reg.out_data <= nco_pkg::SAMPLE_MID;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hreadyout = st_reg.readyout;
  assign hrdata = st_reg.rdata;
  assign hresp = 1'b0;
  assign sine_sample_out = st_reg.out_data;
  assign sample_valid = st_reg.out_valid;
endmodule
`default_nettype wire

/* core/nco_fifo.sv */
// Sample buffer with valid and ready on both sides
`default_nettype none
module nco_fifo #(
  parameter int unsigned WIDTH = 12,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int unsigned AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0]                 wr;
    logic [AW:0]                 rd;
  } nco_fifo_s;

  nco_fifo_s st_reg;
  nco_fifo_s st_next;
  logic      full;
  logic      empty;

  always_comb begin
    st_next = st_reg;
    empty = (st_reg.wr == st_reg.rd);
    full = (st_reg.wr[AW] != st_reg.rd[AW]) && (st_reg.wr[AW-1:0] == st_reg.rd[AW-1:0]);
    in_ready = !full;
    out_valid = !empty;
    out_data = st_reg.mem[st_reg.rd[AW-1:0]];
    if (in_valid && !full) begin
      st_next.mem[st_reg.wr[AW-1:0]] = in_data;
      st_next.wr = st_reg.wr + 1'b1;
    end
    if (out_ready && !empty) begin
      st_next.rd = st_reg.rd + 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
endmodule
`default_nettype wire

/* core/nco_pkg.sv */
// Constants shared by the oscillator core and its sample buffer
`default_nettype none
package nco_pkg;
  // Widths and sizes
  localparam int unsigned FREQ_W     = 64;
  localparam int unsigned WORD_W     = 32;
  localparam int unsigned PHASE_W    = 13;
  localparam int unsigned SAMPLE_W   = 12;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned PIN_W      = 10;
  // Pipeline delays in main clocks
  localparam int unsigned XFER_DELAY = 4;
  localparam int unsigned ACC_DELAY  = 4;
  localparam int unsigned OFS_DELAY  = 4;
  localparam int unsigned LOAD_DELAY = 5;
  // Synchronised pin vector positions
  localparam int unsigned PIN_SCLK   = 0;
  localparam int unsigned PIN_SD     = 1;
  localparam int unsigned PIN_SHIFT_ENABLE_N  = 2;
  localparam int unsigned PIN_MSB    = 3;
  localparam int unsigned PIN_SEL    = 4;
  localparam int unsigned PIN_XFER   = 5;
  localparam int unsigned PIN_ACCEN  = 6;
  localparam int unsigned PIN_LOAD   = 7;
  localparam int unsigned PIN_OFS    = 8;
  // Register byte offsets
  localparam logic [7:0] REG_CTRL    = 8'h00;
  localparam logic [7:0] REG_STATUS  = 8'h04;
  localparam logic [7:0] REG_PHASE   = 8'h08;
  localparam logic [7:0] REG_INCR    = 8'h0C;
  localparam logic [7:0] REG_FREQ_HI = 8'h10;
  localparam logic [7:0] REG_FREQ_LO = 8'h14;
  // Register fields and reset values
  localparam int unsigned CTRL_RUN_BIT  = 0;
  localparam logic        CTRL_RUN_RST  = 1'b1;
  localparam int unsigned STAT_VLD_BIT  = 0;
  localparam int unsigned STAT_RDY_BIT  = 1;
  localparam int unsigned STAT_SEL_BIT  = 2;
  // Phase offsets in quarter turns
  localparam logic [1:0] QTR_0   = 2'h0;
  localparam logic [1:0] QTR_90  = 2'h1;
  localparam logic [1:0] QTR_180 = 2'h2;
  localparam logic [1:0] QTR_270 = 2'h3;
  // Sine table scaling
  localparam logic [12:0] HALF_TURN  = 13'h1000;
  localparam logic [11:0] SAMPLE_MID = 12'h800;
  localparam logic [35:0] SINE_NUM_K = 36'h000001FFC;
  localparam logic [35:0] SINE_DEN_K = 36'h001400000;
  // AHB codes
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

/* test/nco_core_props.sv */
// Port checker for the oscillator core
`default_nettype none
module nco_core_props (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  input wire logic [11:0] sine_sample_out,
  input wire logic        sample_valid,
  input wire logic        sample_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic rd_take;
  assign rd_take = hsel && hready && htrans[1] && !hwrite;
  a_sample_range: assert property (sample_valid |-> sine_sample_out != 12'h000)
    else $error("sample code out of range");
  a_mid_at_reset: assert property ($rose(hresetn) |-> sine_sample_out == 12'h800 && !sample_valid)
    else $error("sample not at midscale after reset");
  a_stream_starts: assert property ($rose(hresetn) |-> ##[1:30] sample_valid)
    else $error("sample stream did not start");
  a_valid_held: assert property (sample_valid && !sample_ready |=> sample_valid)
    else $error("sample valid dropped before taken");
  a_sample_stable: assert property (sample_valid && !sample_ready |=> $stable(sine_sample_out))
    else $error("sample changed before taken");
  a_unmapped_zero: assert property (rd_take && haddr[7:2] > 6'h05 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_hold: assert property (!rd_take |=> $stable(hrdata))
    else $error("read data changed without read");
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
  a_never_wait: assert property (hreadyout == 1'b1)
    else $error("slave inserted wait");
  c_take: cover property (sample_valid && sample_ready);
  c_stall: cover property (sample_valid && !sample_ready [*8]);
  c_unmapped: cover property (rd_take && haddr[7:2] > 6'h05);
endmodule
bind nco_core nco_core_props u_nco_core_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout),
  .hrdata(hrdata), .hresp(hresp), .sine_sample_out(sine_sample_out),
  .sample_valid(sample_valid), .sample_ready(sample_ready));
`default_nettype wire

/* test/nco_ctl_model.sv */
// Serial loader and converter sink facing the oscillator
`default_nettype none
module nco_ctl_model (
  input  wire logic hclk,
  output var logic  sclk,
  output var logic  serial_word_in,
  output var logic  shift_enable_n,
  output var logic  shift_msb_first,
  output var logic  sample_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sclk = 1'b0;
    serial_word_in = 1'b0;
    shift_enable_n = 1'b1;
    shift_msb_first = 1'b1;
    sample_ready = 1'b1;
  end
  // One 64-bit frame, clock idles low between frames
  task automatic send(input logic [63:0] w, input logic msb, input logic en_n);
    int i;
    shift_msb_first <= msb;
    shift_enable_n <= en_n;
    for (i = 0; i < 64; i++) begin
      repeat (4) @(posedge hclk);
      sclk <= 1'b0;
      serial_word_in <= msb ? w[63-i] : w[i];
      repeat (4) @(posedge hclk);
      sclk <= 1'b1;
    end
    repeat (4) @(posedge hclk);
    sclk <= 1'b0;
    repeat (4) @(posedge hclk);
    serial_word_in <= ~serial_word_in;
    shift_enable_n <= 1'b1;
  endtask
  // Converter refuses samples for a while
  task automatic stall(input int n);
    sample_ready <= 1'b0;
    repeat (n) @(posedge hclk);
    sample_ready <= 1'b1;
  endtask
endmodule
`default_nettype wire

/* test/tb_nco_core.sv */
// Testbench for the oscillator core
`default_nettype none
module tb_nco_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, sclk, sdi, sen_n, msb;
  logic wsel, xfer_n, acc_n, load_n, svalid, sready;
  logic [31:0] haddr, hwdata, hrdata, d, p1;
  logic [1:0]  htrans, ofs;
  logic [2:0]  hsize;
  logic [11:0] sample;
  logic [11:0] sine_exp [4] = '{12'h800, 12'hFFF, 12'h001, 12'h800};
  int err_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int i;
  assign hready = hreadyout;
  nco_core u_nco_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .sclk(sclk),
    .serial_word_in(sdi), .shift_enable_n(sen_n), .shift_msb_first(msb),
    .word_select(wsel), .word_transfer_n(xfer_n), .accumulate_enable_n(acc_n),
    .accumulator_load_n(load_n), .phase_offset_code(ofs), .sine_sample_out(sample),
    .sample_valid(svalid), .sample_ready(sready));
  nco_ctl_model u_nco_ctl_model (.hclk(hclk), .sclk(sclk), .serial_word_in(sdi),
    .shift_enable_n(sen_n), .shift_msb_first(msb), .sample_ready(sready));
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      summarize();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic ahb(input logic [31:0] a, input logic wr, input logic [31:0] wd);
    haddr <= a;
    hwrite <= wr;
    htrans <= nco_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    d = hrdata;
  endtask
  task automatic rd(input logic [7:0] a);
    ahb({24'h0, a}, 1'b0, 32'h0);
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b1;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    wsel = 1'b0;
    xfer_n = 1'b1;
    acc_n = 1'b1;
    load_n = 1'b1;
    ofs = 2'h0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rd(nco_pkg::REG_CTRL); check(d, 32'h1);
    ahb(32'h40, 1'b1, 32'hFFFFFFFF);
    rd(8'h40); check(d, 32'h0);
    for (i = 0; i < 4; i++) begin
      ofs <= i[1:0];
      repeat (30) @(posedge hclk);
      check({20'h0, sample}, {20'h0, sine_exp[i]});
    end
    ofs <= 2'h0;
    u_nco_ctl_model.send(64'h0123456789ABCDEF, 1'b1, 1'b0);
    rd(nco_pkg::REG_FREQ_HI); check(d, 32'h01234567);
    rd(nco_pkg::REG_FREQ_LO); check(d, 32'h89ABCDEF);
    u_nco_ctl_model.send(64'hFFFFFFFF00000000, 1'b1, 1'b1);
    rd(nco_pkg::REG_FREQ_LO); check(d, 32'h89ABCDEF);
    u_nco_ctl_model.send(64'h0000040000100000, 1'b0, 1'b0);
    rd(nco_pkg::REG_FREQ_HI); check(d, 32'h00000400);
    for (i = 1; i >= 0; i--) begin
      wsel <= i[0];
      repeat (4) @(posedge hclk);
      xfer_n <= 1'b0;
      repeat (4) @(posedge hclk);
      xfer_n <= 1'b1;
      repeat (12) @(posedge hclk);
      rd(nco_pkg::REG_INCR); check(d, i ? 32'h00100000 : 32'h00000400);
    end
    load_n <= 1'b0;
    acc_n <= 1'b0;
    repeat (12) @(posedge hclk);
    rd(nco_pkg::REG_PHASE); check(d, 32'h00000400);
    load_n <= 1'b1;
    repeat (20) @(posedge hclk);
    acc_n <= 1'b1;
    repeat (12) @(posedge hclk);
    rd(nco_pkg::REG_PHASE); p1 = d;
    check(p1 & 32'h3FF, 32'h0);
    check({31'h0, p1 > 32'h400}, 32'h1);
    repeat (20) @(posedge hclk);
    rd(nco_pkg::REG_PHASE); check(d, p1);
    acc_n <= 1'b0;
    ahb({24'h0, nco_pkg::REG_CTRL}, 1'b1, 32'h0);
    rd(nco_pkg::REG_CTRL); check(d, 32'h0);
    rd(nco_pkg::REG_PHASE); p1 = d;
    repeat (20) @(posedge hclk);
    rd(nco_pkg::REG_PHASE); check(d, p1);
    ahb({24'h0, nco_pkg::REG_CTRL}, 1'b1, 32'h1);
    fork
      u_nco_ctl_model.stall(80);
      begin
        repeat (40) @(posedge hclk);
        rd(nco_pkg::REG_STATUS); check(d & 32'h3, 32'h1);
        rd(nco_pkg::REG_PHASE); p1 = d;
        rd(nco_pkg::REG_PHASE); check(d, p1);
      end
    join
    repeat (40) @(posedge hclk);
    rd(nco_pkg::REG_STATUS); check(d & 32'h3, 32'h3);
    summarize();
  end
endmodule
`default_nettype wire
